// >>> hdl/ctw_pkg.sv
// constants, opcodes and state codes for the transfer and weighted-average slice
package ctw_pkg;
    // opcode pages and codes
    localparam logic [7:0] PAGE_NONE       = 8'h00;
    localparam logic [7:0] PAGE_XFER       = 8'hB7;
    localparam logic [7:0] PAGE_TWO        = 8'h18;
    localparam logic [7:0] OP_COPY_SP_TO_Y = 8'h76;
    localparam logic [7:0] OP_LOAD_SP_FROM_X = 8'h57;
    localparam logic [7:0] OP_LOAD_SP_FROM_Y = 8'h67;
    localparam logic [7:0] OP_SWAP_D_WITH_X = 8'hC5;
    localparam logic [7:0] OP_SWAP_D_WITH_Y = 8'hC6;
    localparam logic [7:0] OP_STACK_AND_WAIT = 8'h3E;
    localparam logic [7:0] OP_WEIGHTED_AVG  = 8'h3C;
    localparam logic [7:0] OP_WAV_RESUME    = 8'h3C;
    // reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0]  CCR_RST  = 8'hD0;
    // stack step counts (index of last step) and stack pointer step sizes
    localparam logic [2:0] WAI_LAST_STEP  = 3'h4;
    localparam logic [2:0] EXIT_LAST_STEP = 3'h2;
    localparam logic [2:0] POP_LAST_STEP  = 3'h2;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    // register load port selects
    localparam logic [2:0] SEL_D   = 3'h0;
    localparam logic [2:0] SEL_X   = 3'h1;
    localparam logic [2:0] SEL_Y   = 3'h2;
    localparam logic [2:0] SEL_SP  = 3'h3;
    localparam logic [2:0] SEL_CCR = 3'h4;
    // sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_WPUSH = 8'h02,
        ST_WWAIT = 8'h04,
        ST_VCHK  = 8'h08,
        ST_VRS   = 8'h10,
        ST_VRF   = 8'h20,
        ST_VEXIT = 8'h40,
        ST_VPOP  = 8'h80
    } ctw_state_t;
endpackage

// >>> hdl/ctw_mac.sv
// one product-sum and weight-sum accumulation step
`timescale 1ns/1ps
`default_nettype none
module ctw_mac (
    input  wire logic [31:0] sop_in,
    input  wire logic [15:0] sow_in,
    input  wire logic [7:0]  sample_in,
    input  wire logic [7:0]  weight_in,
    output logic      [31:0] sop_out,
    output logic      [15:0] sow_out
);
    logic [15:0] product;

    // unsigned 8x8 product added to the product sum, weight added to the weight sum
    assign product = {8'h00, sample_in} * {8'h00, weight_in};
    assign sop_out = sop_in + {16'h0000, product};
    assign sow_out = sow_in + {8'h00, weight_in};
endmodule
`default_nettype wire

// >>> hdl/ctw_core.sv
// transfer, exchange, stack-and-wait and weighted-average execution slice
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1: B7 76 copies SP into Y, one cycle
// RULE2: B7 57 loads SP from X, one cycle
// RULE3: B7 67 loads SP from Y, one cycle
// RULE4: 3E stacks return,Y,X,B:A,CONDITION_CODE_REG then waits
// RULE5: 18 3C sums products into Y:D, weights X
// RULE6: B gives count, X points at samples
// RULE7: interrupt check once every loop iteration
// RULE8: three-word exit stack, three-pop re-entry
// RULE9: 3C restores sums from stack, then continues
// RULE10: B7 C5 swaps D and X, one cycle
// RULE11: B7 C6 swaps D and Y, one cycle
// RULE12: transfers and swaps leave CONDITION_CODE_REG unchanged
module ctw_core (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        op_valid_in,
    input  wire logic [7:0]  op_page_in,
    input  wire logic [7:0]  op_code_in,
    output logic             op_ready_out,
    output logic             done_out,
    input  wire logic [15:0] ret_addr_in,
    input  wire logic        irq_in,
    output logic             wait_out,
    output logic             int_taken_out,
    input  wire logic        wr_en_in,
    input  wire logic [2:0]  wr_sel_in,
    input  wire logic [15:0] wr_data_in,
    output logic      [15:0] mem_addr_out,
    output logic      [15:0] mem_wdata_out,
    output logic             mem_we_out,
    output logic             mem_re_out,
    output logic             mem_byte_out,
    input  wire logic [15:0] mem_rdata_in,
    output logic      [15:0] d_out,
    output logic      [15:0] x_out,
    output logic      [15:0] y_out,
    output logic      [15:0] sp_out,
    output logic      [7:0]  ccr_out
);
    ctw_pkg::ctw_state_t state, next_state;
    logic [2:0]  step, next_step;
    logic [31:0] sop, mac_sop;
    logic [15:0] weight_sum, mac_sow, sp_m2, sp_m1, wai_data, exit_data;
    logic [7:0]  sample;
    logic        take, pg_xfer, dec_xfer, wav_finish, wav_break, wr_ok;
    logic        dec_copy_sp_to_y, dec_load_sp_from_x, dec_load_sp_from_y;
    logic        dec_swap_d_with_x, dec_swap_d_with_y, dec_stack_and_wait;
    logic        dec_weighted_average, dec_wav_resume;
    logic        st_idle, st_wpush, st_vchk, st_vrs, st_vrf, st_vexit, st_vpop;
    // state flags
    assign st_idle  = (state == ctw_pkg::ST_IDLE);
    assign st_wpush = (state == ctw_pkg::ST_WPUSH);
    assign st_vchk  = (state == ctw_pkg::ST_VCHK);
    assign st_vrs   = (state == ctw_pkg::ST_VRS);
    assign st_vrf   = (state == ctw_pkg::ST_VRF);
    assign st_vexit = (state == ctw_pkg::ST_VEXIT);
    assign st_vpop  = (state == ctw_pkg::ST_VPOP);
    // opcode decode, only while idle
    assign take    = op_valid_in & st_idle;
    assign pg_xfer = take & (op_page_in == ctw_pkg::PAGE_XFER);
    assign dec_copy_sp_to_y   = pg_xfer & (op_code_in == ctw_pkg::OP_COPY_SP_TO_Y);
    assign dec_load_sp_from_x = pg_xfer & (op_code_in == ctw_pkg::OP_LOAD_SP_FROM_X);
    assign dec_load_sp_from_y = pg_xfer & (op_code_in == ctw_pkg::OP_LOAD_SP_FROM_Y);
    assign dec_swap_d_with_x  = pg_xfer & (op_code_in == ctw_pkg::OP_SWAP_D_WITH_X);
    assign dec_swap_d_with_y  = pg_xfer & (op_code_in == ctw_pkg::OP_SWAP_D_WITH_Y);
    assign dec_stack_and_wait = take & (op_page_in == ctw_pkg::PAGE_NONE)
                                & (op_code_in == ctw_pkg::OP_STACK_AND_WAIT);
    assign dec_weighted_average = take & (op_page_in == ctw_pkg::PAGE_TWO)
                                  & (op_code_in == ctw_pkg::OP_WEIGHTED_AVG);
    assign dec_wav_resume = take & (op_page_in == ctw_pkg::PAGE_NONE)
                            & (op_code_in == ctw_pkg::OP_WAV_RESUME);
    assign dec_xfer = dec_copy_sp_to_y | dec_load_sp_from_x | dec_load_sp_from_y
                      | dec_swap_d_with_x | dec_swap_d_with_y;
    // loop end and interrupt break, checked between iterations
    assign wav_finish = st_vchk & (d_out[7:0] == 8'h00);
    assign wav_break  = st_vchk & (d_out[7:0] != 8'h00) & irq_in; // [RULE7]
    assign wr_ok      = wr_en_in & st_idle;
    // stack data selection
    assign sp_m2 = sp_out - ctw_pkg::STEP_WORD;
    assign sp_m1 = sp_out - ctw_pkg::STEP_BYTE;
    assign wai_data = (step == 3'h0) ? ret_addr_in :
                      (step == 3'h1) ? y_out :
                      (step == 3'h2) ? x_out :
                      (step == 3'h3) ? {d_out[7:0], d_out[15:8]} :
                      {8'h00, ccr_out}; // [RULE4]
    assign exit_data = (step == 3'h0) ? weight_sum :
                       (step == 3'h1) ? sop[15:0] : sop[31:16]; // [RULE8]
    // memory strobes
    assign mem_we_out   = st_wpush | st_vexit;
    assign mem_re_out   = st_vrs | st_vrf | st_vpop;
    assign mem_byte_out = st_vrs | st_vrf | (st_wpush & (step == ctw_pkg::WAI_LAST_STEP));
    assign mem_addr_out = st_wpush ? ((step == ctw_pkg::WAI_LAST_STEP) ? sp_m1 : sp_m2) :
                          st_vrs   ? x_out :
                          st_vrf   ? y_out :
                          st_vexit ? sp_m2 :
                          st_vpop  ? sp_out : ctw_pkg::WORD_RST; // [RULE6]
    assign mem_wdata_out = st_wpush ? wai_data : st_vexit ? exit_data : ctw_pkg::WORD_RST;
    // handshake outputs
    assign op_ready_out = st_idle;
    assign wait_out     = (state == ctw_pkg::ST_WWAIT);
    // one accumulation step
    ctw_mac u_mac (
        .sop_in    (sop),
        .sow_in    (weight_sum),
        .sample_in (sample),
        .weight_in (mem_rdata_in[7:0]),
        .sop_out   (mac_sop),
        .sow_out   (mac_sow)
    );
    // sequencer next state
    always_comb begin
        next_state = state;
        next_step  = step;
        case (state)
            ctw_pkg::ST_IDLE: begin
                next_step = 3'h0;
                if (dec_stack_and_wait) begin
                    next_state = ctw_pkg::ST_WPUSH;
                end else if (dec_weighted_average) begin
                    next_state = ctw_pkg::ST_VCHK;
                end else if (dec_wav_resume) begin
                    next_state = ctw_pkg::ST_VPOP; // [RULE9]
                end
            end
            ctw_pkg::ST_WPUSH: begin
                next_step = step + 3'h1;
                if (step == ctw_pkg::WAI_LAST_STEP) begin
                    next_state = ctw_pkg::ST_WWAIT;
                end
            end
            ctw_pkg::ST_WWAIT: if (irq_in) next_state = ctw_pkg::ST_IDLE; // [RULE4]
            ctw_pkg::ST_VCHK: begin
                next_step = 3'h0;
                if (wav_finish) begin
                    next_state = ctw_pkg::ST_IDLE;
                end else if (wav_break) begin
                    next_state = ctw_pkg::ST_VEXIT; // [RULE8]
                end else begin
                    next_state = ctw_pkg::ST_VRS;
                end
            end
            ctw_pkg::ST_VRS: next_state = ctw_pkg::ST_VRF;
            ctw_pkg::ST_VRF: next_state = ctw_pkg::ST_VCHK; // [RULE7]
            ctw_pkg::ST_VEXIT: begin
                next_step = step + 3'h1;
                if (step == ctw_pkg::EXIT_LAST_STEP) begin
                    next_state = ctw_pkg::ST_IDLE;
                end
            end
            ctw_pkg::ST_VPOP: begin
                next_step = step + 3'h1;
                if (step == ctw_pkg::POP_LAST_STEP) begin
                    next_state = ctw_pkg::ST_VRS; // [RULE8]
                end
            end
            default: begin
                next_state = ctw_pkg::ST_IDLE;
                next_step  = 3'h0;
            end
        endcase
    end
    // sequencer registers
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state <= ctw_pkg::ST_IDLE;
            step  <= 3'h0;
        end else begin
            state <= next_state;
            step  <= next_step;
        end
    end
    // stack pointer
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            sp_out <= ctw_pkg::WORD_RST;
        end else if (wr_ok && wr_sel_in == ctw_pkg::SEL_SP) begin
            sp_out <= wr_data_in;
        end else if (dec_load_sp_from_x) begin
            sp_out <= x_out; // [RULE2]
        end else if (dec_load_sp_from_y) begin
            sp_out <= y_out; // [RULE3]
        end else if (st_wpush) begin
            sp_out <= (step == ctw_pkg::WAI_LAST_STEP) ? sp_m1 : sp_m2; // [RULE4]
        end else if (st_vexit) begin
            sp_out <= sp_m2; // [RULE8]
        end else if (st_vpop) begin
            sp_out <= sp_out + ctw_pkg::STEP_WORD;
        end
    end
    // index register y: copy, swap, weight pointer, product-sum high word
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            y_out <= ctw_pkg::WORD_RST;
        end else if (wr_ok && wr_sel_in == ctw_pkg::SEL_Y) begin
            y_out <= wr_data_in;
        end else if (dec_copy_sp_to_y) begin
            y_out <= sp_out; // [RULE1]
        end else if (dec_swap_d_with_y) begin
            y_out <= d_out; // [RULE11]
        end else if (st_vrf) begin
            y_out <= y_out + ctw_pkg::STEP_BYTE;
        end else if (wav_finish) begin
            y_out <= sop[31:16]; // [RULE5]
        end
    end
    // index register x: swap, sample pointer, weight sum
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            x_out <= ctw_pkg::WORD_RST;
        end else if (wr_ok && wr_sel_in == ctw_pkg::SEL_X) begin
            x_out <= wr_data_in;
        end else if (dec_swap_d_with_x) begin
            x_out <= d_out; // [RULE10]
        end else if (st_vrs) begin
            x_out <= x_out + ctw_pkg::STEP_BYTE; // [RULE6]
        end else if (wav_finish) begin
            x_out <= weight_sum; // [RULE5]
        end
    end
    // double accumulator: swaps, element count in b, product-sum low word
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            d_out <= ctw_pkg::WORD_RST;
        end else if (wr_ok && wr_sel_in == ctw_pkg::SEL_D) begin
            d_out <= wr_data_in;
        end else if (dec_swap_d_with_x) begin
            d_out <= x_out; // [RULE10]
        end else if (dec_swap_d_with_y) begin
            d_out <= y_out; // [RULE11]
        end else if (st_vrf) begin
            d_out <= {d_out[15:8], d_out[7:0] - 8'h01}; // [RULE6]
        end else if (wav_finish) begin
            d_out <= sop[15:0]; // [RULE5]
        end
    end
    // condition codes: only the load port writes them
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            ccr_out <= ctw_pkg::CCR_RST;
        end else if (wr_ok && wr_sel_in == ctw_pkg::SEL_CCR) begin
            ccr_out <= wr_data_in[7:0]; // [RULE12]
        end
    end
    // running sums: cleared on start, restored on resume
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            sop <= 32'h0000_0000;
            weight_sum <= ctw_pkg::WORD_RST;
        end else if (dec_weighted_average) begin
            sop <= 32'h0000_0000;
            weight_sum <= ctw_pkg::WORD_RST;
        end else if (st_vrf) begin
            sop <= mac_sop; // [RULE5]
            weight_sum <= mac_sow;
        end else if (st_vpop) begin
            if (step == 3'h0) begin
                sop[31:16] <= mem_rdata_in; // [RULE9]
            end else if (step == 3'h1) begin
                sop[15:0] <= mem_rdata_in;
            end else begin
                weight_sum <= mem_rdata_in;
            end
        end
    end
    // sample byte and completion pulses
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            sample        <= 8'h00;
            done_out      <= 1'b0;
            int_taken_out <= 1'b0;
        end else begin
            if (st_vrs) begin
                sample <= mem_rdata_in[7:0];
            end
            done_out      <= dec_xfer | (wait_out & irq_in) | wav_finish;
            int_taken_out <= st_vexit & (step == ctw_pkg::EXIT_LAST_STEP);
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    property p_copy_sp_to_y;
        dec_copy_sp_to_y |=> (y_out == $past(sp_out)) && done_out && op_ready_out;
    endproperty
    a_copy_sp_to_y: assert property (p_copy_sp_to_y) else $error("sp not copied to y"); // [RULE1]
    property p_load_sp_from_x;
        dec_load_sp_from_x |=> (sp_out == $past(x_out)) && done_out;
    endproperty
    a_load_sp_from_x: assert property (p_load_sp_from_x) else $error("sp not from x"); // [RULE2]
    property p_load_sp_from_y;
        dec_load_sp_from_y |=> (sp_out == $past(y_out)) && done_out;
    endproperty
    a_load_sp_from_y: assert property (p_load_sp_from_y) else $error("sp not from y"); // [RULE3]
    property p_stack_and_wait;
        dec_stack_and_wait |=> (mem_we_out && mem_addr_out == $past(sp_out) - 16'h0002)
        ##4 (mem_byte_out && mem_we_out) ##1 (wait_out && sp_out == $past(sp_out, 6) - 16'h0009);
    endproperty
    a_stack_and_wait: assert property (p_stack_and_wait) else $error("stacking wrong"); // [RULE4]
    property p_accumulate;
        st_vrf |=> (weight_sum == $past(weight_sum) + {8'h00, $past(mem_rdata_in[7:0])}) && st_vchk;
    endproperty
    a_accumulate: assert property (p_accumulate) else $error("weight sum wrong"); // [RULE5]
    property p_first_sample;
        st_vchk && !wav_finish && !wav_break
            |=> mem_re_out && mem_byte_out && mem_addr_out == $past(x_out);
    endproperty
    a_first_sample: assert property (p_first_sample) else $error("sample read wrong"); // [RULE6]
    property p_irq_check;
        wav_break |=> st_vexit && !op_ready_out;
    endproperty
    a_irq_check: assert property (p_irq_check) else $error("interrupt not honoured"); // [RULE7]
    property p_exit_seq;
        wav_break |=> mem_we_out [*3] ##1 (op_ready_out && int_taken_out);
    endproperty
    a_exit_seq: assert property (p_exit_seq) else $error("exit sequence wrong"); // [RULE8]
    property p_resume;
        dec_wav_resume |=> (mem_re_out && !mem_byte_out) [*3]
            ##1 (st_vrs && sop[15:0] == $past(mem_rdata_in, 2));
    endproperty
    a_resume: assert property (p_resume) else $error("resume did not restore sums"); // [RULE9]
    property p_swap_x;
        dec_swap_d_with_x |=> (d_out == $past(x_out)) && (x_out == $past(d_out));
    endproperty
    a_swap_x: assert property (p_swap_x) else $error("d and x not swapped"); // [RULE10]
    property p_swap_y;
        dec_swap_d_with_y |=> (d_out == $past(y_out)) && (y_out == $past(d_out));
    endproperty
    a_swap_y: assert property (p_swap_y) else $error("d and y not swapped"); // [RULE11]
    property p_ccr_kept;
        dec_xfer |=> $stable(ccr_out);
    endproperty
    a_ccr_kept: assert property (p_ccr_kept) else $error("condition codes changed"); // [RULE12]
endmodule
`default_nettype wire

// >>> dv/ctw_mem_model.sv
// program and stack memory model with same-cycle reads
`timescale 1ns/1ps
`default_nettype none
module ctw_mem_model (
    input  wire logic        mclk_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        we_in,
    input  wire logic        re_in,
    input  wire logic        byte_in,
    output logic      [15:0] rdata_out
);
    logic [7:0]  m [0:65535];
    logic [15:0] last_rd;
    logic [15:0] rd_val;
    // word view puts the lower address in the high byte; bytes use the low lane
    assign rd_val = byte_in ? {8'h00, m[addr_in]} : {m[addr_in], m[addr_in + 16'h0001]};
    // an unread bus shows the inverse of the last read, never a stale copy
    assign rdata_out = re_in ? rd_val : ~last_rd;
    // writes land at the rising edge
    always @(posedge mclk_in) begin
        if (re_in) begin
            last_rd <= rd_val;
        end
        if (we_in && byte_in) begin
            m[addr_in] <= wdata_in[7:0];
        end else if (we_in) begin
            m[addr_in] <= wdata_in[15:8];
            m[addr_in + 16'h0001] <= wdata_in[7:0];
        end
    end
    initial last_rd = 16'hA5A5;
endmodule
`default_nettype wire

// >>> dv/test_cpu_transfer_wait_wav_ops.sv
// self-checking bench for the transfer, wait and weighted-average slice
`timescale 1ns/1ps
`default_nettype none
module test_cpu_transfer_wait_wav_ops;
    logic        mclk_in = 1'h0, rst_n_in = 1'h0, op_valid_in = 1'h0, irq_in = 1'h0;
    logic [7:0]  op_page_in = 8'h00, op_code_in = 8'h00, ccr_out;
    logic [15:0] ret_addr_in = 16'h0000, wr_data_in = 16'h0000;
    logic        wr_en_in = 1'h0;
    logic [2:0]  wr_sel_in = 3'h0;
    logic        op_ready_out, done_out, wait_out, int_taken_out;
    logic        mem_we_out, mem_re_out, mem_byte_out;
    logic [15:0] mem_addr_out, mem_wdata_out, mem_rdata_in, d_out, x_out, y_out, sp_out;
    logic [31:0] seed = 32'h0000_0020;
    int          failures = 0;
    int          tests_run = 0;

    ctw_core dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .op_valid_in(op_valid_in),
        .op_page_in(op_page_in), .op_code_in(op_code_in), .op_ready_out(op_ready_out),
        .done_out(done_out), .ret_addr_in(ret_addr_in), .irq_in(irq_in),
        .wait_out(wait_out), .int_taken_out(int_taken_out), .wr_en_in(wr_en_in),
        .wr_sel_in(wr_sel_in), .wr_data_in(wr_data_in), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out), .mem_re_out(mem_re_out),
        .mem_byte_out(mem_byte_out), .mem_rdata_in(mem_rdata_in), .d_out(d_out),
        .x_out(x_out), .y_out(y_out), .sp_out(sp_out), .ccr_out(ccr_out));
    ctw_mem_model mem (.mclk_in(mclk_in), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
        .we_in(mem_we_out), .re_in(mem_re_out), .byte_in(mem_byte_out),
        .rdata_out(mem_rdata_in));

    // 40 MHz clock
    initial begin
        forever #12.5 mclk_in = ~mclk_in;
    end

    // verdict and end of run
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // hang guard, well past the longest expected run
    initial begin
        #(25 * 20000);
        failures++;
        close_out();
    end

    // one counted comparison
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // lfsr stimulus source
    function automatic logic [15:0] rnd();
        repeat (7) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0] ^ seed[31:16];
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    // register load through the side port
    task automatic load(input logic [2:0] sel, input logic [15:0] val);
        @(posedge mclk_in);
        wr_en_in <= 1'h1;
        wr_sel_in <= sel;
        wr_data_in <= val;
        @(posedge mclk_in);
        wr_en_in <= 1'h0;
        #1;
    endtask

    // r packs {d, x, y, sp}
    task automatic load_all(input logic [63:0] r, input logic [7:0] cc);
        load(ctw_pkg::SEL_D, r[63:48]);
        load(ctw_pkg::SEL_X, r[47:32]);
        load(ctw_pkg::SEL_Y, r[31:16]);
        load(ctw_pkg::SEL_SP, r[15:0]);
        load(ctw_pkg::SEL_CCR, {8'h00, cc});
    endtask

    // offer one opcode; returns just after the taking edge
    task automatic issue(input logic [7:0] page, input logic [7:0] code);
        @(posedge mclk_in);
        op_valid_in <= 1'h1;
        op_page_in <= page;
        op_code_in <= code;
        @(posedge mclk_in);
        op_valid_in <= 1'h0;
        #1;
    endtask

    // bounded wait for the completion pulse
    task automatic wait_done(input int lim);
        int n;
        n = 0;
        while (done_out !== 1'h1 && n < lim) begin
            tick(1);
            n++;
        end
        check({63'h0, done_out}, 64'h1, "completion pulse");
    endtask

    function automatic logic [15:0] mw(input logic [15:0] a);
        return {mem.m[a], mem.m[a + 16'h0001]};
    endfunction

    // expected {product sum, weight sum} over the first n elements
    function automatic logic [47:0] wsum(input logic [7:0] n);
        logic [31:0] sop;
        logic [15:0] weight_sum;
        sop = 32'h0000_0000;
        weight_sum = 16'h0000;
        for (int i = 0; i < n; i++) begin
            sop = sop + mem.m[16'h1000 + i] * mem.m[16'h2000 + i];
            weight_sum = weight_sum + {8'h00, mem.m[16'h2000 + i]};
        end
        return {sop, weight_sum};
    endfunction

    // expected {d, x, y, sp} after a transfer or swap
    function automatic logic [63:0] xfer_exp(input logic [7:0] code, input logic [63:0] r);
        case (code)
            ctw_pkg::OP_COPY_SP_TO_Y:   return {r[63:32], r[15:0], r[15:0]};
            ctw_pkg::OP_LOAD_SP_FROM_X: return {r[63:16], r[47:32]};
            ctw_pkg::OP_LOAD_SP_FROM_Y: return {r[63:16], r[31:16]};
            ctw_pkg::OP_SWAP_D_WITH_X:  return {r[47:32], r[63:48], r[31:0]};
            default:                    return {r[31:16], r[47:32], r[63:48], r[15:0]};
        endcase
    endfunction

    // main sequence
    initial begin
        logic [63:0] r;
        logic [47:0] s;
        logic [15:0] ra;
        logic [7:0]  cc, n, p;
        logic [7:0]  codes [5];
        codes = '{ctw_pkg::OP_COPY_SP_TO_Y, ctw_pkg::OP_LOAD_SP_FROM_X,
                  ctw_pkg::OP_LOAD_SP_FROM_Y, ctw_pkg::OP_SWAP_D_WITH_X,
                  ctw_pkg::OP_SWAP_D_WITH_Y};
        repeat (5) @(posedge mclk_in);
        rst_n_in <= 1'h1;
        #1;
        check({d_out, x_out, y_out, sp_out}, 64'h0, "registers after reset");
        check({56'h0, ccr_out}, {56'h0, ctw_pkg::CCR_RST}, "flags after reset");
        $display("test reset done");
        // transfers and swaps on random register contents
        for (int i = 0; i < 20; i++) begin
            r = {rnd(), rnd(), rnd(), rnd()};
            ra = rnd();
            cc = ra[7:0];
            load_all(r, cc);
            issue(ctw_pkg::PAGE_XFER, codes[i % 5]);
            check({d_out, x_out, y_out, sp_out}, xfer_exp(codes[i % 5], r),
                  "transfer");
            check({63'h0, done_out}, 64'h1, "done");
            check({56'h0, ccr_out}, {56'h0, cc}, "flags kept");
            tick(1);
            check({63'h0, done_out}, 64'h0, "done pulse length");
        end
        $display("test transfers done");
        // stack and wait, with a load attempt while busy
        r = {rnd(), rnd(), rnd(), 16'h3100};
        ra = rnd();
        cc = ra[15:8];
        load_all(r, cc);
        @(posedge mclk_in);
        ret_addr_in <= ra;
        issue(ctw_pkg::PAGE_NONE, ctw_pkg::OP_STACK_AND_WAIT);
        for (int k = 0; k < 12 && wait_out !== 1'h1; k++) tick(1);
        load(ctw_pkg::SEL_X, ~r[47:32]);
        check({62'h0, wait_out, op_ready_out}, 64'h2, "waiting");
        check({mw(16'h30FE), mw(16'h30FC), mw(16'h30FA), mw(16'h30F8)},
              {ra, r[31:16], r[47:32], r[55:48], r[63:56]}, "stacked words");
        check({56'h0, mem.m[16'h30F7]}, {56'h0, cc}, "stacked flags");
        check({48'h0, sp_out}, 64'h30F7, "stack pointer after stacking");
        @(posedge mclk_in);
        irq_in <= 1'h1;
        wait_done(5);
        @(posedge mclk_in);
        irq_in <= 1'h0;
        check({48'h0, x_out}, {48'h0, r[47:32]}, "load ignored while busy");
        $display("test stack and wait done");
        // full weighted averages: empty, 255 elements, random counts
        for (int t = 0; t < 6; t++) begin
            ra = rnd();
            n = (t == 0) ? 8'h00 : (t == 1) ? 8'hFF : {4'h0, ra[3:0]} + 8'h01;
            for (int i = 0; i < 256; i++) begin
                ra = rnd();
                mem.m[16'h1000 + i] = ra[7:0];
                mem.m[16'h2000 + i] = ra[15:8];
            end
            s = wsum(n);
            load_all({ra[15:8], n, 16'h1000, 16'h2000, 16'h3200}, 8'hD0);
            issue(ctw_pkg::PAGE_TWO, ctw_pkg::OP_WEIGHTED_AVG);
            wait_done(1000);
            check({16'h0, y_out, d_out, x_out}, {16'h0, s}, "weighted sums");
        end
        $display("test weighted average done");
        // break in mid-accumulation, then resume
        n = 8'h0C;
        s = wsum(n);
        load_all({8'h00, n, 16'h1000, 16'h2000, 16'h3300}, 8'hD0);
        issue(ctw_pkg::PAGE_TWO, ctw_pkg::OP_WEIGHTED_AVG);
        ra = rnd();
        tick(int'(ra[3:0]) + 4);
        @(posedge mclk_in);
        irq_in <= 1'h1;
        for (int k = 0; k < 20 && int_taken_out !== 1'h1; k++) tick(1);
        check({63'h0, int_taken_out}, 64'h1, "interrupt exit");
        p = n - d_out[7:0];
        check({48'h0, sp_out}, 64'h32FA, "exit stack depth");
        check({16'h0, mw(16'h32FA), mw(16'h32FC), mw(16'h32FE)}, {16'h0, wsum(p)},
              "partial sums stacked");
        check({48'h0, x_out}, {48'h0, 16'h1000 + {8'h00, p}}, "sample pointer");
        @(posedge mclk_in);
        irq_in <= 1'h0;
        issue(ctw_pkg::PAGE_NONE, ctw_pkg::OP_WAV_RESUME);
        wait_done(1000);
        check({16'h0, y_out, d_out, x_out}, {16'h0, s}, "resumed sums");
        check({48'h0, sp_out}, 64'h3300, "stack unwound");
        $display("test break and resume done");
        close_out();
    end
endmodule
`default_nettype wire
